//--- inc/nv_io_config_defines.vh
// constants for the nonvolatile io configuration shadow bank
// assumes a classic wishbone slave with 32-bit data and word addresses
`ifndef NV_IO_CONFIG_DEFINES_VH
`define NV_IO_CONFIG_DEFINES_VH
// printed locations are register indices; byte address is four times these
`define LOC_DEBOUNCE_EN 5'h0e
`define LOC_TIME_OVR 5'h0f
`define LOC_OUT_SEL 5'h10
`define LOC_OUT_VAL 5'h11
`define LOC_IND_FLAGS 5'h12
`define LOC_SYNC_FLAGS 5'h13
`define LOC_SUBST_ID 5'h14
`define LOC_TRIM_FIRST 5'h15
`define LOC_TRIM_LAST 5'h17
// own registers; 0x1b is not decoded and answers with err
`define LOC_CTRL 5'h18
`define LOC_STATUS 5'h19
`define LOC_ID_EXT 5'h1a
`define LOC_DOUT_REG 5'h1b
// field positions
`define BIT_PIN_OVR 3
`define BIT_ENH_STATUS 0
`define BIT_TWO_LAMP 1
`define BIT_FAULT_INV 2
`define BIT_SAFETY 3
`define BIT_SYNC_EN 0
`define BIT_SYNC_PIN 1
`define BIT_FOUR_IO 2
`define BIT_ID_LOCK 3
`define BIT_AB_SEL 3
`define BIT_CTRL_INIT 0
`define BIT_CTRL_EXT 1
`define NIB_RESET 4'h0
`define DEBOUNCE_BASE 8'h01
`endif

//--- hw/nv_io_config_bank.v
// shadow bank for nonvolatile io configuration (locations 0xe to 0x17)
// assumes synchronous pins and a classic wishbone master on clk_sys
`timescale 1ns/1ns
`include "nv_io_config_defines.vh"
// Contract
// - per-pin debounce enable at 0xe
// - 0xf bits 2..0 set debounce time
// - 0xf bit 3: parameter pin one overrides filter
// - 0x10 selects output source, 0x11 static value
// - 0x12 bit 0 enhanced status, lamp two on
// - 0x12 bit 1 two lamp scheme, lamp two
// - 0x12 bit 2 inverts fault input first
// - 0x12 bit 3 safety mode, special input routing
// - 0x13 bit 0 enables synced io
// - 0x13 bit 1: pin two gates synced io
// - 0x13 bit 2 four in four out extended
// - 0x13 bit 3 locks id extension one writes
// - extended mode locks only bits 2..0
// - locked id read returns 0x14 value
// - 0x15..0x17 trim: no access
module nv_io_config_bank (
    input wire clk_sys,
    input wire rst_b,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    output reg wb_err_o,
    input wire [3:0] data_input_pins,
    input wire parameter_pin_one,
    input wire parameter_pin_two,
    input wire fault_indication_input,
    input wire extended_address_mode,
    input wire [3:0] data_output_register,
    input wire lamp_one_pattern,
    input wire lamp_two_pattern,
    output reg [3:0] filtered_inputs,
    output reg [3:0] data_output_pins,
    output reg fault_processed,
    output reg first_lamp_output,
    output reg second_lamp_output,
    output reg second_lamp_enable,
    output reg enhanced_status_mode,
    output reg two_lamp_scheme,
    output reg safety_mode,
    output reg synced_io_active,
    output reg four_in_four_out_enable,
    output reg [3:0] id_ext_one_read
);
    // software stages a value in the staging bank, init copies it to live shadows
    reg [3:0] stage [0:6];
    reg [3:0] live [0:6];
    reg init_done;
    reg [3:0] id_ext_one;
    reg [7:0] deb_cnt [0:3];
    reg [3:0] next_filtered;
    reg next_ack;
    reg next_err;
    reg [31:0] next_rdata;
    // one loop index per process keeps every variable single-driven
    integer lv_i;
    integer st_i;
    integer nf_i;
    integer cnt_i;
    integer flt_i;
    integer out_i;

    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire [4:0] idx = wb_adr_i[6:2];
    wire hit_stage = (idx >= `LOC_DEBOUNCE_EN) && (idx <= `LOC_SUBST_ID);
    wire hit_trim = (idx >= `LOC_TRIM_FIRST) && (idx <= `LOC_TRIM_LAST);
    wire [2:0] sidx = idx[2:0] - 3'h6;
    wire [3:0] ind = live[4];
    wire [3:0] syn = live[5];
    wire id_lock = syn[`BIT_ID_LOCK];
    wire wr_lane = req & wb_we_i & wb_sel_i[0];
    wire wr_stage = wr_lane & hit_stage;
    wire wr_ctrl = wr_lane & (idx == `LOC_CTRL) & wb_dat_i[`BIT_CTRL_INIT];
    wire wr_id = wr_lane & (idx == `LOC_ID_EXT);

    function [7:0] debounce_limit;
        input [2:0] code;
        begin
            debounce_limit = `DEBOUNCE_BASE << code;
        end
    endfunction

    function [3:0] id_write_merge;
        input [3:0] old;
        input [3:0] wr;
        input lock;
        input ext;
        begin
            if (!lock)
                id_write_merge = wr;
            else if (ext)
                id_write_merge = {wr[`BIT_AB_SEL], old[2:0]};
            else
                id_write_merge = old;
        end
    endfunction

    // a pin override either hands the decision to the pin or leaves the gate open, so the feature follows its enable
    function pin_gate;
        input use_pin;
        input pin;
        begin
            if (use_pin)
                pin_gate = pin;
            else
                pin_gate = 1'b1;
        end
    endfunction

    function lamp_two_on;
        input [3:0] flags;
        begin
            lamp_two_on = flags[`BIT_ENH_STATUS] | flags[`BIT_TWO_LAMP];
        end
    endfunction

    function [3:0] safety_route;
        input [3:0] pins;
        input safety;
        begin
            if (safety)
                safety_route = {pins[0], pins[1], pins[2], pins[3]};
            else
                safety_route = pins;
        end
    endfunction

    // decode of one request; the answer is registered, one cycle after it is taken
    always @* begin
        next_ack = 1'b0;
        next_err = 1'b0;
        next_rdata = 32'h0;
        if (hit_trim) begin
            next_err = 1'b1;
        end else if (hit_stage) begin
            next_ack = 1'b1;
            next_rdata = {28'h0, stage[sidx]};
        end else if (idx == `LOC_CTRL) begin
            next_ack = 1'b1;
        end else if (idx == `LOC_STATUS) begin
            next_ack = 1'b1;
            next_rdata = {16'h0, filtered_inputs, ind, syn, 3'h0, init_done};
        end else if (idx == `LOC_ID_EXT) begin
            next_ack = 1'b1;
            next_rdata = {28'h0, id_ext_one_read};
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= req & next_ack;
            wb_err_o <= req & next_err;
            if (req)
                wb_dat_o <= next_rdata;
        end
    end

    // re-initialization reloads the live shadows from staging one cycle later
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            init_done <= 1'b0;
        else if (wr_ctrl)
            init_done <= 1'b0;
        else
            init_done <= 1'b1;
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (lv_i = 0; lv_i < 7; lv_i = lv_i + 1)
                live[lv_i] <= `NIB_RESET;
        end else if (!init_done) begin
            for (lv_i = 0; lv_i < 7; lv_i = lv_i + 1)
                live[lv_i] <= stage[lv_i];
        end
    end

    // staged values do nothing until the next initialization copies them
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (st_i = 0; st_i < 7; st_i = st_i + 1)
                stage[st_i] <= `NIB_RESET;
        end else if (wr_stage) begin
            stage[sidx] <= wb_dat_i[3:0];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            id_ext_one <= `NIB_RESET;
        end else if (wr_id) begin
            id_ext_one <= id_write_merge(id_ext_one, wb_dat_i[3:0], id_lock,
                extended_address_mode);
        end
    end

    // debounce: input must hold a new level for the full time constant
    always @* begin
        next_filtered = filtered_inputs;
        for (nf_i = 0; nf_i < 4; nf_i = nf_i + 1)
            if (deb_cnt[nf_i] >= debounce_limit(live[1][2:0]))
                next_filtered[nf_i] = data_input_pins[nf_i];
    end

    wire filter_on = pin_gate(live[1][`BIT_PIN_OVR], parameter_pin_one);
    wire [3:0] filter_mask = live[1][`BIT_PIN_OVR] ? {4{filter_on}} : live[0];
    wire fault_in = fault_indication_input ^ ind[`BIT_FAULT_INV];
    wire [3:0] routed = safety_route(data_input_pins, ind[`BIT_SAFETY]);
    wire lamp_two_live = lamp_two_on(ind);

    // counters saturate rather than wrap, so a long disagreement cannot restart
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (cnt_i = 0; cnt_i < 4; cnt_i = cnt_i + 1)
                deb_cnt[cnt_i] <= 8'h0;
        end else begin
            for (cnt_i = 0; cnt_i < 4; cnt_i = cnt_i + 1) begin
                if (!filter_mask[cnt_i] || data_input_pins[cnt_i] == filtered_inputs[cnt_i])
                    deb_cnt[cnt_i] <= 8'h0;
                else if (deb_cnt[cnt_i] != 8'hff)
                    deb_cnt[cnt_i] <= deb_cnt[cnt_i] + 8'h1;
            end
        end
    end

    // filtered pins bypass the safety routing; only unfiltered pins are rerouted
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            filtered_inputs <= 4'h0;
        end else begin
            for (flt_i = 0; flt_i < 4; flt_i = flt_i + 1)
                filtered_inputs[flt_i] <= filter_mask[flt_i] ? next_filtered[flt_i] :
                    routed[flt_i];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            data_output_pins <= 4'h0;
        end else begin
            for (out_i = 0; out_i < 4; out_i = out_i + 1)
                data_output_pins[out_i] <= live[2][out_i] ? live[3][out_i] :
                    data_output_register[out_i];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fault_processed <= 1'b0;
        end else begin
            fault_processed <= fault_in;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            enhanced_status_mode <= 1'b0;
        end else begin
            enhanced_status_mode <= ind[`BIT_ENH_STATUS];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            two_lamp_scheme <= 1'b0;
        end else begin
            two_lamp_scheme <= ind[`BIT_TWO_LAMP];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            second_lamp_enable <= 1'b0;
        end else begin
            second_lamp_enable <= lamp_two_live;
        end
    end

    // the lamp patterns come from outside; this block only gates and times them
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            first_lamp_output <= 1'b0;
        end else begin
            first_lamp_output <= lamp_one_pattern;
        end
    end

    // legacy boards leave lamp two unconnected, so it stays low unless enabled
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            second_lamp_output <= 1'b0;
        end else begin
            second_lamp_output <= lamp_two_live & lamp_two_pattern;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            safety_mode <= 1'b0;
        end else begin
            safety_mode <= ind[`BIT_SAFETY];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            synced_io_active <= 1'b0;
        end else begin
            synced_io_active <= syn[`BIT_SYNC_EN] &
                pin_gate(syn[`BIT_SYNC_PIN], parameter_pin_two);
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            four_in_four_out_enable <= 1'b0;
        end else begin
            four_in_four_out_enable <= syn[`BIT_FOUR_IO] & extended_address_mode;
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            id_ext_one_read <= 4'h0;
        end else begin
            id_ext_one_read <= id_lock ? live[6] : id_ext_one;
        end
    end
endmodule

//--- dv/nv_io_config_bank_assertions.sv
// port checker for the config shadow bank
// assumes word addresses in adr[6:2] and one answer per request
`timescale 1ns/1ns
module nv_io_config_bank_assertions (
    input wire clk_sys,
    input wire rst_b,
    input wire [31:0] wb_adr_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire fault_indication_input,
    input wire fault_processed,
    input wire second_lamp_enable,
    input wire enhanced_status_mode,
    input wire two_lamp_scheme
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    idle_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");
    trim_refused_a: assert property (req && wb_adr_i[6:2] inside {[5'h15:5'h17]}
        |=> wb_err_o && !wb_ack_o) else $error("trim access not refused");
    unmapped_err_a: assert property (req && wb_adr_i[6:2] == 5'h1b |=> wb_err_o)
        else $error("unmapped access not refused");
    one_answer_a: assert property (!(wb_ack_o && wb_err_o)) else $error("ack and err");
    lamp_two_on_a: assert property (enhanced_status_mode || two_lamp_scheme
        |-> second_lamp_enable) else $error("second lamp off");
    fault_follow_a: assert property ($changed(fault_indication_input)
        |=> $changed(fault_processed)) else $error("fault path stuck");
    upper_zero_a: assert property (wb_ack_o && $past(wb_adr_i[6:2]) != 5'h19
        |-> wb_dat_o[31:4] == 28'h0) else $error("upper read bits set");
endmodule
bind nv_io_config_bank nv_io_config_bank_assertions nv_io_config_bank_assertions_inst (.*);

//--- dv/nv_bus_master.sv
// classic wishbone master standing in for the configuration tool
// assumes the slave answers each request with ack or err
`timescale 1ns/1ns
module nv_bus_master (
    input wire logic clk_sys,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [31:0] wb_dat_o,
    output logic [31:0] wb_adr_i = 32'h0,
    output logic [31:0] wb_dat_i = 32'h0,
    output logic [3:0] wb_sel_i = 4'h0,
    output logic wb_we_i = 1'b0,
    output logic wb_cyc_i = 1'b0,
    output logic wb_stb_i = 1'b0
);
    // hung flags a missing answer so the bench can stop instead of hanging
    task automatic xfer(input logic we, input logic [4:0] idx, input logic [3:0] d,
                        output logic [31:0] rd, output logic err, output logic hung);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= {25'h0, idx, 2'h0};
        wb_dat_i <= {28'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (!wb_ack_o && !wb_err_o && n < 20);
        rd = wb_dat_o;
        err = wb_err_o;
        hung = !wb_ack_o && !wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
endmodule

//--- dv/nv_io_config_bank_bench.sv
// bench for the config shadow bank: bus tasks plus pin checks
// assumes the bank answers within a few cycles and reinit takes one cycle
`timescale 1ns/1ns
module nv_io_config_bank_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i, filtered_inputs, data_output_pins, id_ext_one_read;
    logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, er;
    logic [3:0] data_input_pins = 4'h1, data_output_register = 4'h3;
    logic parameter_pin_one = 1'b0, parameter_pin_two = 1'b0, lamp_one_pattern = 1'b0;
    logic lamp_two_pattern = 1'b0, fault_indication_input = 1'b0, extended_address_mode = 1'b1;
    logic fault_processed, first_lamp_output, second_lamp_output, second_lamp_enable;
    logic enhanced_status_mode, two_lamp_scheme, safety_mode, synced_io_active;
    logic four_in_four_out_enable;
    int mismatches = 0;
    int cmp_count = 0;
    nv_io_config_bank nv_io_config_bank_inst (.*);
    nv_bus_master nv_bus_master_inst (.*);
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic acc(input logic we, input logic [4:0] idx, input logic [3:0] d);
        logic hung;
        nv_bus_master_inst.xfer(we, idx, d, rd, er, hung);
        if (hung) begin
            mismatches++;
            stop_test;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        acc(1'b1, 5'h0e, 4'h6);
        acc(1'b1, 5'h12, 4'hf);
        acc(1'b1, 5'h13, 4'hd);
        acc(1'b1, 5'h14, 4'h9);
        acc(1'b0, 5'h0e, 4'h0);
        chk(rd, 32'h6);
        fault_indication_input <= 1'b1;
        lamp_one_pattern <= 1'b1;
        lamp_two_pattern <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(fault_processed, 1'b1);
        chk(safety_mode, 1'b0);
        chk(second_lamp_output, 1'b0);
        acc(1'b1, 5'h18, 4'h1);
        repeat (4) @(posedge clk_sys);
        chk(fault_processed, 1'b0);
        chk({enhanced_status_mode, two_lamp_scheme, second_lamp_enable}, 3'h7);
        chk(second_lamp_output, 1'b1);
        chk(first_lamp_output, 1'b1);
        chk(safety_mode, 1'b1);
        chk(filtered_inputs, 4'h8);
        chk(synced_io_active, 1'b1);
        chk(four_in_four_out_enable, 1'b1);
        chk(id_ext_one_read, 4'h9);
        acc(1'b0, 5'h16, 4'h0);
        chk(er, 1'b1);
        acc(1'b0, 5'h1a, 4'h0);
        chk(rd, 32'h9);
        acc(1'b0, 5'h1b, 4'h0);
        chk(er, 1'b1);
        acc(1'b1, 5'h1a, 4'hf);
        extended_address_mode <= 1'b0;
        acc(1'b1, 5'h1a, 4'h7);
        acc(1'b1, 5'h10, 4'h5);
        acc(1'b1, 5'h11, 4'ha);
        acc(1'b1, 5'h12, 4'h0);
        acc(1'b1, 5'h13, 4'h7);
        acc(1'b1, 5'h0f, 4'h2);
        acc(1'b1, 5'h18, 4'h1);
        repeat (4) @(posedge clk_sys);
        chk(data_output_pins, 4'h2);
        chk(second_lamp_output, 1'b0);
        chk(synced_io_active, 1'b0);
        chk(four_in_four_out_enable, 1'b0);
        chk(fault_processed, 1'b1);
        chk(safety_mode, 1'b0);
        chk(filtered_inputs, 4'h1);
        chk(id_ext_one_read, 4'h8);
        acc(1'b0, 5'h1a, 4'h0);
        chk(rd, 32'h8);
        parameter_pin_two <= 1'b1;
        data_input_pins <= 4'h7;
        repeat (4) @(posedge clk_sys);
        chk(filtered_inputs, 4'h1);
        chk(synced_io_active, 1'b1);
        repeat (2) @(posedge clk_sys);
        chk(filtered_inputs, 4'h7);
        stop_test;
    end
endmodule
